// >>> hdl/tcm_pkg.sv
// shared constants and types of the two-channel mux control block
package tcm_pkg;

  // widths of the serial byte and the address strap group
  localparam int BYTE_W = 8;
  localparam int ADDR_PIN_W = 3;
  localparam int DEV_ADDR_W = 7;
  localparam int ADDR_HI_W = DEV_ADDR_W - ADDR_PIN_W;

  // upper slave address bits above the strap pins, value arbitrary
  localparam logic [ADDR_HI_W-1:0] DEV_ADDR_HI_DEFAULT = 4'h7;

  // bit counter values of one byte
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_FULL = 4'h8;

  // direction bit of the address byte
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;

  // control byte field positions
  localparam int chan_enable_bit = 2;
  localparam int chan_sel_mid_bit = 1;
  localparam int chan_sel_lsb = 0;
  localparam int STAT_IRQ1_BIT = 5;
  localparam int STAT_IRQ0_BIT = 4;
  localparam int CTRL_STORED_W = 4;

  // reset values
  localparam logic [CTRL_STORED_W-1:0] CTRL_RESET = 4'h0;
  localparam logic [1:0] READ_TOP_ZERO = 2'h0;

  // downstream connect vector, one bit per channel
  localparam logic [1:0] CONNECT_NONE = 2'h0;
  localparam logic [1:0] CONNECT_CHAN0 = 2'h1;
  localparam logic [1:0] CONNECT_CHAN1 = 2'h2;

  // idle levels seen by the synchronisers at reset
  localparam logic [1:0] LINE_IDLE = 2'h3;
  localparam logic [1:0] IRQ_IDLE = 2'h3;
  localparam logic [2:0] STRAP_RESET = 3'h0;

  // upstream serial pair after synchronisation
  typedef struct packed {
    logic scl;
    logic sda;
  } tcm_line_type;

  // active-high pending flags per channel
  typedef struct packed {
    logic chan1;
    logic chan0;
  } tcm_irq_type;

  // serial slave states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WRITE,
    ST_WRITE_ACK,
    ST_READ,
    ST_READ_ACK
  } tcm_state_type;

endpackage

// >>> hdl/tcm_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module tcm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);

  // widths below one cannot be served
  if (WIDTH < 1) begin : g_bad_width
    $error("tcm_sync needs a width of at least one");
  end

  // one pair of flops per bit; the first stage feeds only the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q;
    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        meta_q <= RESET_VAL[i];
        syncOut[i] <= RESET_VAL[i];
      end else begin
        meta_q <= pinIn[i];
        syncOut[i] <= meta_q;
      end
    end
  end

endmodule
`default_nettype wire

// >>> hdl/tcm_bus_cond.sv
// start, stop and clock edge detection on the synchronised upstream pair
`timescale 1ns/1ps
`default_nettype none
module tcm_bus_cond
  import tcm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // synchronised lines
  input wire tcm_line_type lineIn,
  // one-cycle events
  output logic startSeen,
  output logic stopSeen,
  output logic sclRise,
  output logic sclFall
);

  tcm_line_type prev_q;

  // previous line levels
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= LINE_IDLE;
    end else begin
      prev_q <= lineIn;
    end
  end

  // data edges with clock high are bus conditions
  assign startSeen = prev_q.scl && lineIn.scl && prev_q.sda && !lineIn.sda;
  assign stopSeen = prev_q.scl && lineIn.scl && !prev_q.sda && lineIn.sda;
  assign sclRise = !prev_q.scl && lineIn.scl;
  assign sclFall = prev_q.scl && !lineIn.scl;

endmodule
`default_nettype wire

// >>> hdl/tcm_mux_ctrl.sv
// serial slave, control byte, channel select and interrupt merge of the mux
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - low three slave address bits come from three strap pins
// - last address bit one means read, zero means write
// - every written data byte lands in the control byte; last wins
// - control byte can be written and read over the serial bus
// - low bits 10x pick channel bit0; 0xx or 11x pick none
// - never more than one downstream channel connected
// - new selection connects only after a stop on the upstream bus
// - reset clears control byte and serial state; no channel connected
// - interrupt output pulled low while either channel input is low
// - interrupt detection works whether or not that channel is selected
// - read byte bit5 shows channel 1 pending, bit4 channel 0
// - interrupt levels are captured when the read byte is loaded
// - both pending bits may be set together
// - interrupt inputs double as general inputs read via status bits
// - serial interface works from static up to 400 kHz
// - device pulls data low in the ack slot after a matching address byte and after each received data byte
// - data falling with clock high is start, rising is stop
module tcm_mux_ctrl
  import tcm_pkg::*;
#(
  parameter logic [ADDR_HI_W-1:0] DEV_ADDR_HI = DEV_ADDR_HI_DEFAULT
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // upstream serial pair
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // address straps
  input wire logic addr_sel_pin_lo,
  input wire logic addr_sel_pin_mid,
  input wire logic addr_sel_pin_hi,
  // per-channel interrupt inputs
  input wire logic chan0_irq_in_n,
  input wire logic chan1_irq_in_n,
  // merged open-drain interrupt output
  output logic irqOut,
  output logic irqOutOe,
  // pass gate enables of the downstream pairs
  output logic down0Connect,
  output logic down1Connect
);

  // synchronised pins
  tcm_line_type line;
  logic [ADDR_PIN_W-1:0] strap;
  logic [1:0] irqSyncN;
  tcm_irq_type irqPend;

  // bus events
  logic startSeen;
  logic stopSeen;
  logic sclRise;
  logic sclFall;

  // serial engine state
  tcm_state_type state_q;
  logic [3:0] cnt_q;
  logic [BYTE_W-1:0] shift_q;
  logic [BYTE_W-1:0] tx_q;
  logic rw_q;
  logic masterAck_q;
  logic sdaLow_q;

  // control byte, downstream connect and interrupt output
  logic [CTRL_STORED_W-1:0] ctrl_q;
  logic [1:0] connect_q;
  logic irqLow_q;

  // derived terms
  logic [DEV_ADDR_W-1:0] myAddr;
  logic addrMatch;
  logic byteDone;
  logic [BYTE_W-1:0] readByte;
  logic [1:0] selDecode;

  // upstream pair through two flops each
  tcm_sync #(
    .WIDTH(2),
    .RESET_VAL(LINE_IDLE)
  ) u_line_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pinIn({scl, sdaIn}),
    .syncOut(line)
  );

  // strap pins through two flops
  tcm_sync #(
    .WIDTH(ADDR_PIN_W),
    .RESET_VAL(STRAP_RESET)
  ) u_strap_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pinIn({addr_sel_pin_hi, addr_sel_pin_mid, addr_sel_pin_lo}),
    .syncOut(strap)
  );

  // interrupt inputs through two flops
  tcm_sync #(
    .WIDTH(2),
    .RESET_VAL(IRQ_IDLE)
  ) u_irq_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pinIn({chan1_irq_in_n, chan0_irq_in_n}),
    .syncOut(irqSyncN)
  );

  // start, stop and clock edges
  tcm_bus_cond u_cond (
    .clock(clock),
    .rst_b(rst_b),
    .lineIn(line),
    .startSeen(startSeen),
    .stopSeen(stopSeen),
    .sclRise(sclRise),
    .sclFall(sclFall)
  );

  // pending flags, independent of the selected channel
  assign irqPend.chan1 = !irqSyncN[1];
  assign irqPend.chan0 = !irqSyncN[0];

  // own address: fixed upper bits, straps below
  assign myAddr = {DEV_ADDR_HI, strap};
  assign addrMatch = (shift_q[BYTE_W-1:1] == myAddr);
  assign byteDone = sclFall && (cnt_q == CNT_FULL);

  // byte returned on a read
  always_comb begin
    readByte = '0;
    readByte[BYTE_W-1:STAT_IRQ1_BIT+1] = READ_TOP_ZERO;
    readByte[STAT_IRQ1_BIT] = irqPend.chan1;
    readByte[STAT_IRQ0_BIT] = irqPend.chan0;
    readByte[CTRL_STORED_W-1:0] = ctrl_q;
  end

  // channel decode of the stored low bits
  always_comb begin
    selDecode = CONNECT_NONE;
    if (ctrl_q[chan_enable_bit] && !ctrl_q[chan_sel_mid_bit]) begin
      if (ctrl_q[chan_sel_lsb]) begin
        selDecode = CONNECT_CHAN1;
      end else begin
        selDecode = CONNECT_CHAN0;
      end
    end
  end

  // serial state, bit counter and direction
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
      rw_q <= DIR_WRITE;
      masterAck_q <= 1'b0;
    end else if (startSeen) begin
      state_q <= ST_ADDR;
      cnt_q <= CNT_ZERO;
    end else if (stopSeen) begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (sclRise) begin
            cnt_q <= cnt_q + CNT_ONE;
          end else if (byteDone) begin
            cnt_q <= CNT_ZERO;
            rw_q <= shift_q[0];
            state_q <= addrMatch ? ST_ADDR_ACK : ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall) begin
            if (rw_q == DIR_READ) begin
              state_q <= ST_READ;
              cnt_q <= CNT_ONE;
            end else begin
              state_q <= ST_WRITE;
              cnt_q <= CNT_ZERO;
            end
          end
        end
        ST_WRITE: begin
          if (sclRise) begin
            cnt_q <= cnt_q + CNT_ONE;
          end else if (byteDone) begin
            cnt_q <= CNT_ZERO;
            state_q <= ST_WRITE_ACK;
          end
        end
        ST_WRITE_ACK: begin
          if (sclFall) begin
            state_q <= ST_WRITE;
          end
        end
        ST_READ: begin
          if (sclFall) begin
            if (cnt_q == CNT_FULL) begin
              cnt_q <= CNT_ZERO;
              state_q <= ST_READ_ACK;
            end else begin
              cnt_q <= cnt_q + CNT_ONE;
            end
          end
        end
        ST_READ_ACK: begin
          if (sclRise) begin
            masterAck_q <= !line.sda;
            if (line.sda) begin
              state_q <= ST_IDLE;
            end
          end else if (sclFall && masterAck_q) begin
            state_q <= ST_READ;
            cnt_q <= CNT_ONE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // receive shifter, sampled on the rising clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= '0;
    end else if (sclRise && (state_q == ST_ADDR || state_q == ST_WRITE)) begin
      shift_q <= {shift_q[BYTE_W-2:0], line.sda};
    end
  end

  // transmit shifter, loaded with live interrupt levels
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_q <= '0;
    end else if (sclFall) begin
      if (state_q == ST_ADDR_ACK && rw_q == DIR_READ) begin
        tx_q <= {readByte[BYTE_W-2:0], 1'b0};
      end else if (state_q == ST_READ_ACK && masterAck_q) begin
        tx_q <= {readByte[BYTE_W-2:0], 1'b0};
      end else if (state_q == ST_READ) begin
        tx_q <= {tx_q[BYTE_W-2:0], 1'b0};
      end
    end
  end

  // data line drive, changed only while the clock is low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sdaLow_q <= 1'b0;
    end else if (startSeen || stopSeen) begin
      sdaLow_q <= 1'b0;
    end else if (sclFall) begin
      case (state_q)
        ST_ADDR: begin
          sdaLow_q <= byteDone && addrMatch;
        end
        ST_ADDR_ACK: begin
          sdaLow_q <= (rw_q == DIR_READ) ? !readByte[BYTE_W-1] : 1'b0;
        end
        ST_WRITE: begin
          sdaLow_q <= byteDone;
        end
        ST_READ: begin
          sdaLow_q <= (cnt_q == CNT_FULL) ? 1'b0 : !tx_q[BYTE_W-1];
        end
        ST_READ_ACK: begin
          sdaLow_q <= masterAck_q && !readByte[BYTE_W-1];
        end
        default: begin
          sdaLow_q <= 1'b0;
        end
      endcase
    end
  end

  // control byte, last written byte wins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
    end else if (byteDone && state_q == ST_WRITE) begin
      ctrl_q <= shift_q[CTRL_STORED_W-1:0];
    end
  end

  // downstream connect follows the selection only at a stop
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      connect_q <= CONNECT_NONE;
    end else if (stopSeen) begin
      connect_q <= selDecode;
    end
  end

  // merged interrupt, low while any input is low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irqLow_q <= 1'b0;
    end else begin
      irqLow_q <= irqPend.chan0 || irqPend.chan1;
    end
  end

  // open-drain pins only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe = sdaLow_q;
  assign irqOut = 1'b0;
  assign irqOutOe = irqLow_q;
  assign down0Connect = connect_q[0];
  assign down1Connect = connect_q[1];

endmodule
`default_nettype wire

// >>> verif/tcm_mux_ctrl_properties.sv
// port-level assertions of the mux control block
`timescale 1ns/1ps
`default_nettype none
module tcm_mux_ctrl_properties
  import tcm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // upstream serial pair
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // straps and interrupts
  input wire logic addr_sel_pin_lo,
  input wire logic addr_sel_pin_mid,
  input wire logic addr_sel_pin_hi,
  input wire logic chan0_irq_in_n,
  input wire logic chan1_irq_in_n,
  input wire logic irqOut,
  input wire logic irqOutOe,
  // pass gate enables
  input wire logic down0Connect,
  input wire logic down1Connect
);
  logic [3:0] stopAge_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // cycles since the last stop seen on the raw pins, saturating
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) stopAge_q <= 4'hf;
    else if (scl && $rose(sdaIn)) stopAge_q <= 4'h0;
    else if (stopAge_q != 4'hf) stopAge_q <= stopAge_q + 4'h1;
  end
  a_one_channel: assert property (!(down0Connect && down1Connect))
    else $error("both channels connected");
  a_irq_low_merge: assert property ((!chan0_irq_in_n || !chan1_irq_in_n) [*5] |-> irqOutOe)
    else $error("interrupt output not pulled low");
  a_irq_high_idle: assert property ((chan0_irq_in_n && chan1_irq_in_n) [*5] |-> !irqOutOe)
    else $error("interrupt output low with idle inputs");
  a_connect_after_stop: assert property (
    ($changed(down0Connect) || $changed(down1Connect)) |-> stopAge_q < 4'h8)
    else $error("connect changed without a stop");
  a_ack_scl_low: assert property ($rose(sdaOe) |-> !scl)
    else $error("data pulled low while clock high");
  a_ack_holds: assert property ($rose(sdaOe) |=> sdaOe [*3])
    else $error("data pull released too early");
  a_reset_release: assert property (
    $rose(rst_b) |-> !down0Connect && !down1Connect && !sdaOe && !irqOutOe)
    else $error("outputs not idle after reset");
  a_open_drain_zero: assert property (sdaOut == 1'b0 && irqOut == 1'b0)
    else $error("open drain value not zero");
  // main scenarios reached
  c_chan0: cover property ($rose(down0Connect));
  c_chan1: cover property ($rose(down1Connect));
  c_irq: cover property ($rose(irqOutOe));
endmodule
`default_nettype wire

// >>> verif/tcm_i2c_master.sv
// behavioural upstream bus master driving the serial pair
`timescale 1ns/1ps
`default_nettype none
module tcm_i2c_master (
  // clock for pacing
  input wire logic clock,
  // resolved data line
  input wire logic sdaWire,
  // driven lines, high means released
  output logic scl,
  output logic sdaDrv
);
  // bus idle, clock stands still outside frames
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // wait falling edges, 12 clocks give the 48 ns link period
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // one bit, data set mid-low, sampled mid-high
  task automatic bitx(input logic b, output logic r);
    tick(3);
    sdaDrv = b;
    tick(3);
    scl = 1'b1;
    tick(3);
    r = sdaWire;
    tick(3);
    scl = 1'b0;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sdaDrv = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(3);
    sdaDrv = 1'b0;
    tick(3);
    scl = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    tick(3);
    sdaDrv = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(3);
    sdaDrv = 1'b1;
    tick(3);
  endtask
  // byte msb first plus ack slot; ackOut high releases or ends a read
  task automatic xfer(input logic [7:0] txd, input logic ackOut,
                      output logic [7:0] rxd, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitx(txd[i], b);
      rxd[i] = b;
    end
    bitx(ackOut, ack);
  endtask
endmodule
`default_nettype wire

// >>> verif/two_channel_i2c_mux_ctrl_tb.sv
// self-checking bench of the mux control block
`timescale 1ns/1ps
`default_nettype none
module two_channel_i2c_mux_ctrl_tb;
  import tcm_pkg::*;
  logic clock, rst_b, scl, sdaDrv, sdaOut, sdaOe, irqOut, irqOutOe;
  logic down0Connect, down1Connect;
  logic [2:0] strap;
  logic [1:0] irqN;
  logic addrSelLo, addrSelMid, addrSelHi, irq0N, irq1N;
  logic [7:0] d;
  logic [11:0] rows [7];
  int errors = 0;
  int num_checks = 0;
  wire logic sdaWire = sdaDrv & ~sdaOe;
  // strap and interrupt pins as separate lines
  assign {addrSelHi, addrSelMid, addrSelLo} = strap;
  assign {irq1N, irq0N} = irqN;
  tcm_i2c_master u_tcm_i2c_master (.clock(clock), .sdaWire(sdaWire), .scl(scl),
    .sdaDrv(sdaDrv));
  tcm_mux_ctrl u_tcm_mux_ctrl (.clock(clock), .rst_b(rst_b), .scl(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_sel_pin_lo(addrSelLo), .addr_sel_pin_mid(addrSelMid),
    .addr_sel_pin_hi(addrSelHi), .chan0_irq_in_n(irq0N), .chan1_irq_in_n(irq1N),
    .irqOut(irqOut), .irqOutOe(irqOutOe), .down0Connect(down0Connect),
    .down1Connect(down1Connect));
  // clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // addressed frame carrying one data byte, left open before stop
  task automatic wr(input logic [7:0] dat);
    logic [7:0] rx;
    logic ack;
    u_tcm_i2c_master.start();
    u_tcm_i2c_master.xfer({DEV_ADDR_HI_DEFAULT, strap, DIR_WRITE}, 1'b1, rx, ack);
    compare("addr ack", 8'h00, {7'h0, ack});
    u_tcm_i2c_master.xfer(dat, 1'b1, rx, ack);
    compare("data ack", 8'h00, {7'h0, ack});
  endtask
  // one-byte read ended by a nack and stop
  task automatic rd(output logic [7:0] dat);
    logic ack;
    u_tcm_i2c_master.start();
    u_tcm_i2c_master.xfer({DEV_ADDR_HI_DEFAULT, strap, DIR_READ}, 1'b1, dat, ack);
    compare("read ack", 8'h00, {7'h0, ack});
    u_tcm_i2c_master.xfer(8'hff, 1'b1, dat, ack);
    u_tcm_i2c_master.stop();
  endtask
  // hang guard
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
  // rows: irq inputs, expected connect, written byte
  initial begin
    logic [7:0] rx;
    logic ack;
    rows = '{{2'h3, 2'h0, 8'h00}, {2'h3, 2'h1, 8'h04}, {2'h2, 2'h2, 8'h05},
             {2'h1, 2'h0, 8'h06}, {2'h0, 2'h0, 8'h07}, {2'h3, 2'h2, 8'hfd},
             {2'h2, 2'h0, 8'h0b}};
    rst_b = 1'b0;
    strap = 3'h5;
    irqN = 2'h3;
    u_tcm_i2c_master.tick(4);
    rst_b = 1'b1;
    u_tcm_i2c_master.tick(8);
    rd(d);
    compare("reset read", 8'h00, d);
    foreach (rows[i]) begin
      irqN = rows[i][11:10];
      d = {6'h0, down1Connect, down0Connect};
      wr(rows[i][7:0]);
      compare("held connect", d, {6'h0, down1Connect, down0Connect});
      u_tcm_i2c_master.stop();
      u_tcm_i2c_master.tick(4);
      compare("connect", {6'h0, rows[i][9:8]}, {6'h0, down1Connect, down0Connect});
      rd(d);
      compare("read", {2'h0, ~rows[i][11:10], rows[i][3:0]}, d);
      compare("irq out", {7'h0, ~&rows[i][11:10]}, {7'h0, irqOutOe});
    end
    // several bytes in one frame, last one wins
    irqN = 2'h3;
    wr(8'h04);
    u_tcm_i2c_master.xfer(8'h05, 1'b1, rx, ack);
    u_tcm_i2c_master.stop();
    u_tcm_i2c_master.tick(4);
    compare("last byte", 8'h02, {6'h0, down1Connect, down0Connect});
    // every strap value answers; a wrong address and its data are ignored
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      u_tcm_i2c_master.tick(4);
      u_tcm_i2c_master.start();
      u_tcm_i2c_master.xfer({DEV_ADDR_HI_DEFAULT, strap, DIR_WRITE}, 1'b1, rx, ack);
      compare("strap ack", 8'h00, {7'h0, ack});
      u_tcm_i2c_master.start();
      u_tcm_i2c_master.xfer({DEV_ADDR_HI_DEFAULT, ~strap, DIR_WRITE}, 1'b1, rx, ack);
      compare("foreign nack", 8'h01, {7'h0, ack});
      u_tcm_i2c_master.xfer(8'h04, 1'b1, rx, ack);
      u_tcm_i2c_master.stop();
    end
    compare("foreign kept", 8'h02, {6'h0, down1Connect, down0Connect});
    // channel 1 request from two devices on one line, serviced by the master
    wr(8'h04);
    u_tcm_i2c_master.stop();
    irqN = 2'h1;
    u_tcm_i2c_master.tick(4);
    compare("irq raised", 8'h01, {7'h0, irqOutOe});
    rd(d);
    compare("irq source", 8'h24, d);
    wr(8'h05);
    u_tcm_i2c_master.stop();
    u_tcm_i2c_master.tick(4);
    compare("service connect", 8'h02, {6'h0, down1Connect, down0Connect});
    // two-byte poll: second device still holds the line, then lets go mid-byte
    u_tcm_i2c_master.start();
    u_tcm_i2c_master.xfer({DEV_ADDR_HI_DEFAULT, strap, DIR_READ}, 1'b1, rx, ack);
    compare("poll ack", 8'h00, {7'h0, ack});
    fork
      u_tcm_i2c_master.xfer(8'hff, 1'b0, d, ack);
      begin
        u_tcm_i2c_master.tick(40);
        irqN = 2'h3;
      end
    join
    compare("second source", 8'h25, d);
    u_tcm_i2c_master.xfer(8'hff, 1'b1, d, ack);
    u_tcm_i2c_master.stop();
    compare("fresh capture", 8'h05, d);
    compare("irq cleared", 8'h00, {7'h0, irqOutOe});
    // reset in mid-run drops the selection
    rst_b = 1'b0;
    u_tcm_i2c_master.tick(4);
    compare("reset connect", 8'h00, {6'h0, down1Connect, down0Connect});
    rst_b = 1'b1;
    u_tcm_i2c_master.tick(8);
    rd(d);
    compare("reread", 8'h00, d);
    print_verdict();
  end
endmodule
bind tcm_mux_ctrl tcm_mux_ctrl_properties u_tcm_mux_ctrl_properties (.clock(clock),
  .rst_b(rst_b), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .addr_sel_pin_lo(addr_sel_pin_lo), .addr_sel_pin_mid(addr_sel_pin_mid),
  .addr_sel_pin_hi(addr_sel_pin_hi), .chan0_irq_in_n(chan0_irq_in_n),
  .chan1_irq_in_n(chan1_irq_in_n), .irqOut(irqOut), .irqOutOe(irqOutOe),
  .down0Connect(down0Connect), .down1Connect(down1Connect));
`default_nettype wire
